// ---- src/rpm_unit.sv ----
/*
 patch match unit: two address comparators on the fetch path, one control register.
 assumes fetch and sfr requests come from core logic on clk_sys, no synchronising needed.
*/
`timescale 1ns/1ns
module rpm_unit
	import rpm_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// fetch path
	input  wire rpm_fetch_t  fetch_in,
	output logic             patch_branch,
	output logic [15:0]      patch_target,
	// sfr access
	input  wire rpm_sfr_t    sfr_in,
	output logic [7:0]       sfr_rdata,
	output logic             sfr_hit
);
	logic [7:0]  patch_control;
	logic [7:0]  next_patch_control;
	logic [15:0] patch_address [2];
	logic [15:0] next_patch_address [2];
	logic [1:0]  match;
	logic [7:0]  wr_val;
	logic [7:0]  next_rdata;
	logic        opcode_fetch;

	assign opcode_fetch = fetch_in.fetch && fetch_in.opcode;

	// two comparators, each gated by its enable
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_cmp
			localparam int EN_BIT = g ? RPM_BIT_EN1 : RPM_BIT_EN0;
			assign match[g] = opcode_fetch && patch_control[EN_BIT]
				&& (fetch_in.addr == patch_address[g]);
		end
	endgenerate

	// combinational so the fetch is replaced in the same cycle
	assign patch_branch = |match;
	assign patch_target = RPM_PATCH_VECTOR;

	always_comb begin
		wr_val = sfr_in.wdata;
		if (sfr_in.bit_op) begin
			// bit manipulation: modify one bit of the current value
			wr_val = patch_control;
			wr_val[sfr_in.bit_sel] = sfr_in.wdata[0];
		end
		next_patch_control = patch_control;
		next_patch_address = patch_address;
		if (sfr_in.wr) begin
			if (sfr_in.addr == RPM_ADDR_CTRL) begin
				// writing 1 to a hit bit is not allowed, so it never sets one
				next_patch_control = wr_val & RPM_CTRL_MASK
					& patch_control | wr_val & RPM_CTRL_MASK
					& ~(8'h01 << RPM_BIT_HIT0) & ~(8'h01 << RPM_BIT_HIT1);
			end else if (sfr_in.addr == RPM_ADDR_PA0_LO) begin
				next_patch_address[0][7:0] = sfr_in.wdata;
			end else if (sfr_in.addr == RPM_ADDR_PA0_HI) begin
				next_patch_address[0][15:8] = sfr_in.wdata;
			end else if (sfr_in.addr == RPM_ADDR_PA1_LO) begin
				next_patch_address[1][7:0] = sfr_in.wdata;
			end else if (sfr_in.addr == RPM_ADDR_PA1_HI) begin
				next_patch_address[1][15:8] = sfr_in.wdata;
			end
		end
		// set wins over a clear in the same cycle; never self-cleared
		if (match[0])
			next_patch_control[RPM_BIT_HIT0] = 1'b1;
		if (match[1])
			next_patch_control[RPM_BIT_HIT1] = 1'b1;
	end

	always_comb begin
		next_rdata = sfr_rdata;
		// holds between reads so the core may sample late
		if (sfr_in.rd) begin
			next_rdata = 8'h00;
			if (sfr_in.addr == RPM_ADDR_CTRL) begin
				next_rdata = patch_control;
			end else if (sfr_in.addr == RPM_ADDR_PA0_LO) begin
				next_rdata = patch_address[0][7:0];
			end else if (sfr_in.addr == RPM_ADDR_PA0_HI) begin
				next_rdata = patch_address[0][15:8];
			end else if (sfr_in.addr == RPM_ADDR_PA1_LO) begin
				next_rdata = patch_address[1][7:0];
			end else if (sfr_in.addr == RPM_ADDR_PA1_HI) begin
				next_rdata = patch_address[1][15:8];
			end
		end
	end

	assign sfr_hit = (sfr_in.addr == RPM_ADDR_CTRL) || (sfr_in.addr == RPM_ADDR_PA0_LO)
		|| (sfr_in.addr == RPM_ADDR_PA0_HI) || (sfr_in.addr == RPM_ADDR_PA1_LO)
		|| (sfr_in.addr == RPM_ADDR_PA1_HI);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			patch_control    <= RPM_CTRL_RESET;
			patch_address[0] <= RPM_ADDR_RESET;
			patch_address[1] <= RPM_ADDR_RESET;
			sfr_rdata        <= 8'h00;
		end else begin
			patch_control <= next_patch_control;
			patch_address <= next_patch_address;
			sfr_rdata     <= next_rdata;
		end
	end

	property p_branch_sets_hit0;
		@(posedge clk_sys) disable iff (!rst_b)
		match[0] |=> patch_control[RPM_BIT_HIT0];
	endproperty
	a_branch_sets_hit0: assert property (p_branch_sets_hit0) else $error("hit0 not set");

	property p_branch_sets_hit1;
		@(posedge clk_sys) disable iff (!rst_b)
		match[1] |=> patch_control[RPM_BIT_HIT1];
	endproperty
	a_branch_sets_hit1: assert property (p_branch_sets_hit1) else $error("hit1 not set");

	property p_disabled_no_branch;
		@(posedge clk_sys) disable iff (!rst_b)
		!patch_control[RPM_BIT_EN0] && !patch_control[RPM_BIT_EN1] |-> !patch_branch;
	endproperty
	a_disabled_no_branch: assert property (p_disabled_no_branch) else $error("branch seen");

	property p_only_opcode;
		@(posedge clk_sys) disable iff (!rst_b)
		patch_branch |-> fetch_in.fetch && fetch_in.opcode;
	endproperty
	a_only_opcode: assert property (p_only_opcode) else $error("branch off opcode");

	property p_enabled_match;
		@(posedge clk_sys) disable iff (!rst_b)
		opcode_fetch && patch_control[RPM_BIT_EN0] && fetch_in.addr == patch_address[0]
			|-> patch_branch;
	endproperty
	a_enabled_match: assert property (p_enabled_match) else $error("missed match");

	property p_vector;
		@(posedge clk_sys) disable iff (!rst_b)
		patch_branch |-> patch_target == RPM_PATCH_VECTOR;
	endproperty
	a_vector: assert property (p_vector) else $error("wrong vector");

	property p_hit_sticky;
		@(posedge clk_sys) disable iff (!rst_b)
		patch_control[RPM_BIT_HIT0] && !sfr_in.wr |=> patch_control[RPM_BIT_HIT0];
	endproperty
	a_hit_sticky: assert property (p_hit_sticky) else $error("hit0 lost");

	property p_hit_no_sw_set;
		@(posedge clk_sys) disable iff (!rst_b)
		!patch_control[RPM_BIT_HIT1] && !match[1] |=> !patch_control[RPM_BIT_HIT1];
	endproperty
	a_hit_no_sw_set: assert property (p_hit_no_sw_set) else $error("hit1 set by write");

	property p_bit_write;
		@(posedge clk_sys) disable iff (!rst_b)
		sfr_in.wr && sfr_in.bit_op && sfr_in.addr == RPM_ADDR_CTRL
			&& sfr_in.bit_sel == 3'(RPM_BIT_EN1)
			|=> patch_control[RPM_BIT_EN1] == $past(sfr_in.wdata[0]);
	endproperty
	a_bit_write: assert property (p_bit_write) else $error("bit write lost");

	sequence s_ctrl_write;
		sfr_in.wr && sfr_in.addr == RPM_ADDR_CTRL;
	endsequence

	property p_reset_values;
		@(posedge clk_sys)
		!rst_b |=> patch_control == RPM_CTRL_RESET && patch_address[0] == RPM_ADDR_RESET
			&& patch_address[1] == RPM_ADDR_RESET && sfr_rdata == 8'h00;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("bad reset");

	property p_hit0_clear;
		@(posedge clk_sys) disable iff (!rst_b)
		s_ctrl_write ##0 !wr_val[RPM_BIT_HIT0] && !match[0] |=> !patch_control[RPM_BIT_HIT0];
	endproperty
	a_hit0_clear: assert property (p_hit0_clear) else $error("hit0 not cleared");

	// set must win when the handler clears in the cycle of a match
	property p_hit1_set_wins;
		@(posedge clk_sys) disable iff (!rst_b)
		s_ctrl_write ##0 match[1] |=> patch_control[RPM_BIT_HIT1];
	endproperty
	a_hit1_set_wins: assert property (p_hit1_set_wins) else $error("hit1 lost");

	property p_enable_write;
		@(posedge clk_sys) disable iff (!rst_b)
		s_ctrl_write ##0 !sfr_in.bit_op
			|=> patch_control[RPM_BIT_EN0] == $past(sfr_in.wdata[RPM_BIT_EN0])
			&& patch_control[RPM_BIT_EN1] == $past(sfr_in.wdata[RPM_BIT_EN1]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable lost");

	property p_upper_zero;
		@(posedge clk_sys) disable iff (!rst_b)
		patch_control[7:4] == 4'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("unused bits set");

	property p_enabled_match1;
		@(posedge clk_sys) disable iff (!rst_b)
		fetch_in.fetch && fetch_in.opcode && patch_control[RPM_BIT_EN1]
			&& fetch_in.addr == patch_address[1] |-> patch_branch;
	endproperty
	a_enabled_match1: assert property (p_enabled_match1) else $error("missed match1");

	property p_rdata_hold;
		@(posedge clk_sys) disable iff (!rst_b)
		!sfr_in.rd |=> $stable(sfr_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

	property p_rdata_ctrl;
		@(posedge clk_sys) disable iff (!rst_b)
		sfr_in.rd && sfr_in.addr == RPM_ADDR_CTRL |=> sfr_rdata == $past(patch_control);
	endproperty
	a_rdata_ctrl: assert property (p_rdata_ctrl) else $error("control read wrong");
endmodule : rpm_unit

// ---- src/rpm_pkg.sv ----
/*
 patch unit package: register addresses, bit positions, reset values, vector, types.
 assumes an 8-bit cpu with 16-bit addresses and a simple sfr strobe bus.
*/
// Notes on behaviour
// - compare every opcode fetch address with both addresses
// - per-comparator enable gates its match
// - match sets that comparator's hit flag
// - match redirects fetch to vector F7FDH
// - reset clears control register to 00H
// - hit flags stay set until software clears
// - control register takes bit and byte writes
// - enable 0 at bit 1, enable 1 at bit 3
// - reset clears both address registers to 0000H
package rpm_pkg;
	localparam logic [15:0] RPM_ADDR_CTRL    = 16'hFF8A;
	localparam logic [15:0] RPM_ADDR_PA0_LO  = 16'hFF38;
	localparam logic [15:0] RPM_ADDR_PA0_HI  = 16'hFF39;
	localparam logic [15:0] RPM_ADDR_PA1_LO  = 16'hFF3A;
	localparam logic [15:0] RPM_ADDR_PA1_HI  = 16'hFF3B;
	localparam int          RPM_BIT_HIT0     = 0;
	localparam int          RPM_BIT_EN0      = 1;
	localparam int          RPM_BIT_HIT1     = 2;
	localparam int          RPM_BIT_EN1      = 3;
	localparam logic [7:0]  RPM_CTRL_MASK    = 8'h0F;
	localparam logic [7:0]  RPM_CTRL_RESET   = 8'h00;
	localparam logic [15:0] RPM_ADDR_RESET   = 16'h0000;
	localparam logic [15:0] RPM_PATCH_VECTOR = 16'hF7FD;

	typedef struct packed {
		logic        fetch;
		logic        opcode;
		logic [15:0] addr;
	} rpm_fetch_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        bit_op;
		logic [2:0]  bit_sel;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} rpm_sfr_t;
endpackage : rpm_pkg

// ---- verification/rpm_core_model.sv ----
/*
 core fetch model: turns bench fetch requests into fetch cycles and follows redirects.
 assumes the patch unit answers combinationally within the fetch cycle.
*/
`timescale 1ns/1ns
module rpm_core_model
	import rpm_pkg::*;
(
	// clock
	input  wire logic        clk_sys,
	// bench request
	input  wire logic        req,
	input  wire logic        req_op,
	input  wire logic [15:0] req_addr,
	// patch unit side
	input  wire logic        patch_branch,
	input  wire logic [15:0] patch_target,
	output rpm_fetch_t       fetch_in,
	output logic [15:0]      pc
);
	logic [15:0] last_addr = 16'h0000;
	// idle bus toggles so a stale address cannot match by luck
	always_comb fetch_in = req ? {1'b1, req_op, req_addr} : {2'b00, ~last_addr};
	always @(posedge clk_sys) begin
		last_addr <= req ? req_addr : ~last_addr;
		if (req)
			pc <= patch_branch ? patch_target : req_addr + 16'h0001;
	end
endmodule : rpm_core_model

// ---- verification/testbench.sv ----
/*
 bench for the patch match unit: sfr and fetch sequences with expected values.
 assumes rpm_unit and rpm_core_model; 100 MHz clock.
*/
`timescale 1ns/1ns
module testbench;
	import rpm_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	rpm_sfr_t    sfr_in = '0;
	logic        req = 1'b0;
	logic        req_op = 1'b0;
	logic [15:0] req_addr = 16'h0000;
	rpm_fetch_t  fetch_in;
	logic        patch_branch;
	logic [15:0] patch_target;
	logic [15:0] pc;
	logic [7:0]  sfr_rdata;
	logic        sfr_hit;
	int          miscompares = 0;
	int          checks_done = 0;
	rpm_unit rpm_unit_i (.clk_sys(clk_sys), .rst_b(rst_b), .fetch_in(fetch_in),
		.patch_branch(patch_branch), .patch_target(patch_target), .sfr_in(sfr_in),
		.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit));
	rpm_core_model rpm_core_model_i (.clk_sys(clk_sys), .req(req), .req_op(req_op),
		.req_addr(req_addr), .patch_branch(patch_branch), .patch_target(patch_target),
		.fetch_in(fetch_in), .pc(pc));
	initial forever #5 clk_sys = ~clk_sys;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bo = 1'b0,
		input logic [2:0] bs = 3'h0);
		@(negedge clk_sys) sfr_in = '{1'b1, 1'b0, bo, bs, a, d};
		@(negedge clk_sys) sfr_in.wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic h = 1'b1);
		@(negedge clk_sys) sfr_in = '{1'b0, 1'b1, 1'b0, 3'h0, a, 8'h00};
		#1 chk({15'h0000, sfr_hit}, {15'h0000, h});
		@(negedge clk_sys) sfr_in.rd = 1'b0;
		chk({8'h00, sfr_rdata}, {8'h00, exp});
	endtask : rd
	task automatic fetch(input logic [15:0] a, input logic op, input logic br);
		@(negedge clk_sys) {req, req_op, req_addr} = {1'b1, op, a};
		#1 chk({15'h0000, patch_branch}, {15'h0000, br});
		@(negedge clk_sys) req = 1'b0;
		chk(pc, br ? RPM_PATCH_VECTOR : a + 16'h0001);
	endtask : fetch
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	// generous: the sequence needs well under 200 cycles
	initial begin
		#20000;
		miscompares++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys) rst_b = 1'b1;
		rd(RPM_ADDR_CTRL, 8'h00);
		for (int i = 0; i < 4; i++)
			rd(RPM_ADDR_PA0_LO + 16'(i), 8'h00);
		$display("test reset values done");
		wr(RPM_ADDR_PA0_LO, 8'h34);
		wr(RPM_ADDR_PA0_HI, 8'h12);
		wr(RPM_ADDR_PA1_LO, 8'h78);
		wr(RPM_ADDR_PA1_HI, 8'h56);
		rd(RPM_ADDR_PA0_HI, 8'h12);
		fetch(16'h1234, 1'b1, 1'b0);
		wr(RPM_ADDR_CTRL, 8'h0A);
		rd(RPM_ADDR_CTRL, 8'h0A);
		$display("test setup done");
		fetch(16'h1234, 1'b1, 1'b1);
		chk(patch_target, RPM_PATCH_VECTOR);
		fetch(16'h1234, 1'b0, 1'b0);
		rd(RPM_ADDR_CTRL, 8'h0B);
		wr(RPM_ADDR_CTRL, 8'h00, 1'b1, 3'h1);
		fetch(16'h1234, 1'b1, 1'b0);
		rd(RPM_ADDR_CTRL, 8'h09);
		fetch(16'h5678, 1'b1, 1'b1);
		rd(RPM_ADDR_CTRL, 8'h0D);
		$display("test match done");
		wr(RPM_ADDR_CTRL, 8'h00, 1'b1, 3'h0);
		rd(RPM_ADDR_CTRL, 8'h0C);
		fork
			wr(RPM_ADDR_CTRL, 8'h00, 1'b1, 3'h2);
			fetch(16'h5678, 1'b1, 1'b1);
		join
		rd(RPM_ADDR_CTRL, 8'h0C);
		wr(RPM_ADDR_CTRL, 8'h00, 1'b1, 3'h3);
		fetch(16'h5678, 1'b1, 1'b0);
		rd(RPM_ADDR_CTRL, 8'h04);
		wr(RPM_ADDR_CTRL, 8'h00, 1'b1, 3'h2);
		wr(RPM_ADDR_CTRL, 8'h01, 1'b1, 3'h1);
		rd(RPM_ADDR_CTRL, 8'h02);
		fetch(16'h1234, 1'b1, 1'b1);
		rd(RPM_ADDR_CTRL, 8'h03);
		$display("test bit writes done");
		rd(16'hFF3C, 8'h00, 1'b0);
		@(negedge clk_sys) rst_b = 1'b0;
		@(negedge clk_sys) rst_b = 1'b1;
		rd(RPM_ADDR_CTRL, 8'h00);
		rd(RPM_ADDR_PA1_HI, 8'h00);
		$display("test clear and reset done");
		end_sim();
	end
endmodule : testbench
